// [dv/rx_peer.sv]
`timescale 1ns/1ps

module rx_peer (
	input  wire logic       clk,
	input  wire logic       in_ready,
	output logic            sof,
	output logic            valid,
	output logic [7:0]      data,
	output logic            eof,
	output logic            crc_err,
	input  wire logic       out_valid,
	output logic            out_ready,
	input  wire logic [7:0] out_data
);
	logic       stall;
	logic [2:0] cyc;
	int         n_refused;
	logic [7:0] got_q[$];

	initial begin
		sof = 1'b0;
		valid = 1'b0;
		data = 8'h00;
		eof = 1'b0;
		crc_err = 1'b0;
		out_ready = 1'b0;
		stall = 1'b0;
		cyc = 3'h0;
		n_refused = 0;
	end

	// Slow sink: one ready cycle in eight while stalling
	always @(negedge clk) begin
		cyc <= cyc + 3'h1;
		out_ready <= !stall || (cyc == 3'h0);
	end

	always @(posedge clk) begin
		if (out_valid && out_ready)
			got_q.push_back(out_data);
	end

	// Byte held until the block takes it
	task automatic put(input logic [7:0] d, input logic first, output logic ok);
		ok = 1'b0;
		for (int k = 0; k < 200 && !ok; k++) begin
			@(negedge clk);
			sof = first;
			valid = 1'b1;
			data = d;
			ok = in_ready;
			if (!ok)
				n_refused++;
		end
	endtask

	task automatic frame(input logic [7:0] a0, a1, input int n, input logic crc, output logic ok);
		logic t;
		put(a0, 1'b1, ok);
		put(a1, 1'b0, t);
		ok &= t;
		for (int i = 0; i < n; i++) begin
			put(i[7:0], 1'b0, t);
			ok &= t;
		end
		@(negedge clk);
		valid = 1'b0;
		sof = 1'b0;
		data = ~data;
		eof = 1'b1;
		crc_err = crc;
		@(negedge clk);
		eof = 1'b0;
		crc_err = ~crc;
	endtask
endmodule // rx_peer

// [dv/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module tb_top;
	import dchan_pkg::*;
	// Arbitrary value
	localparam logic [1:0] VER = 2'b11;
	logic        clk, reset_n, wr, rd, main_ext_mask, ok;
	logic [7:0]  addr, wdata, rdata, rx_data, rx_out_data;
	logic [3:0]  ind, sbits;
	logic [15:0] pv;
	logic [5:0]  rx_avail;
	logic        ext_summary, tx_self_reset, tx_idle_fill, rx_sof, rx_valid, rx_in_ready;
	logic        rx_eof, rx_crc_err, rx_out_valid, rx_out_ready;
	int          n_mismatch, n_compared, n_exp;
	logic [7:0]  ra[13] = '{8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12,
	                        8'h13, 8'h16, 8'h17, 8'h30};
	logic [7:0]  rv[13] = '{8'h00, 8'hFF, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
	                        8'h00, {VER, 6'h00}, 8'h00, 8'h00};
	logic [7:0]  a0s[5] = '{8'h12, 8'h14, 8'h10, 8'hFE, 8'h20};
	logic [7:0]  a1s[5] = '{8'h45, 8'h45, 8'h47, 8'h33, 8'hFF};
	int          keep[5] = '{2, 0, 0, 2, 2};

	dchan_hdlc_status_addr_filter #(.VERSION(VER)) dchan_hdlc_status_addr_filter_i (
		.CLK(clk), .RESET_N(reset_n), .CE(1'b1), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .MAIN_EXT_MASK(main_ext_mask), .EXT_SUMMARY(ext_summary),
		.TRANSMIT_RESET_CMD(pv[13]), .RECEIVE_RESET_CMD(pv[14]), .RECEIVE_ACK_CMD(pv[15]),
		.TX_UNDERRUN(pv[6]), .TX_COLLISION(pv[5]), .TX_OVERWRITE(pv[12]),
		.TX_OPEN_FLAG(pv[10]), .TX_CLOSE_DONE(pv[11]), .TX_SELF_RESET(tx_self_reset),
		.TX_IDLE_FILL(tx_idle_fill), .TIMER1_EXPIRED(pv[1]), .TIMER2_ZERO(pv[4]),
		.SERIAL_BUS_PENDING(pv[3]), .INDICATION_CODE(ind), .S_CHANNEL_BITS(sbits),
		.RX_DATA_OVERFLOW(pv[8]), .RX_FRAME_OVERFLOW(pv[7]), .RX_ABORT(pv[9]),
		.RX_SOF(rx_sof), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_IN_READY(rx_in_ready),
		.RX_EOF(rx_eof), .RX_CRC_ERR(rx_crc_err), .RX_OUT_VALID(rx_out_valid),
		.RX_OUT_READY(rx_out_ready), .RX_OUT_DATA(rx_out_data), .RX_AVAIL(rx_avail));

	rx_peer rx_peer_i (
		.clk(clk), .in_ready(rx_in_ready), .sof(rx_sof), .valid(rx_valid), .data(rx_data),
		.eof(rx_eof), .crc_err(rx_crc_err), .out_valid(rx_out_valid),
		.out_ready(rx_out_ready), .out_data(rx_out_data));

	task automatic complete_run();
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		`CHK($sformatf("reg %h", a), e, rdata)
	endtask

	// Index 0 and 2 change the level inputs, others pulse one cycle
	task automatic pulse(input int b);
		@(negedge clk);
		if (b == 0)
			sbits = sbits + 4'h1;
		else if (b == 2)
			ind = ind + 4'h1;
		else
			pv[b] = 1'b1;
		@(negedge clk);
		pv = '0;
	endtask

	task automatic wait_q(input int n);
		for (int j = 0; j < 100 && rx_peer_i.got_q.size() != n; j++)
			@(negedge clk);
		`CHK("stored bytes", n, rx_peer_i.got_q.size())
	endtask

	task automatic rx_frame(input logic [7:0] a0, a1, input int n, input logic crc,
	                        input logic [7:0] st, input logic [7:0] hi);
		int c;
		c = n + 2;
		rx_peer_i.frame(a0, a1, n, crc, ok);
		`CHK("frame sent", 1'b1, ok)
		reg_rd(ADDR_RX_STATUS, st);
		reg_rd(ADDR_CNT_LOW, c[7:0]);
		reg_rd(ADDR_CNT_HIGH, hi);
		`CHK("avail", ((c % 32) == 0) ? 6'h20 : 6'(c % 32), rx_avail)
		pulse(15);
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#400000;
		n_mismatch++;
		complete_run();
	end

	initial begin
		reset_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		main_ext_mask = 1'b0;
		ind = 4'h0;
		sbits = 4'h0;
		pv = '0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		for (int k = 0; k < 13; k++)
			reg_rd(ra[k], rv[k]);
		for (int k = 14; k < 20; k++) begin
			reg_wr(8'(k), 8'(k) ^ 8'hA5);
			reg_rd(8'(k), 8'(k) ^ 8'hA5);
			reg_wr(8'(k), 8'h00);
		end
		reg_wr(ADDR_RX_STATUS, 8'hFF);
		reg_rd(ADDR_RX_STATUS, 8'h20);
		pulse(1);
		reg_rd(ADDR_EXT_FLAGS, 8'h00);
		`CHK("summary", 1'b1, ext_summary)
		main_ext_mask = 1'b1;
		reg_wr(ADDR_EXT_MASK, 8'h00);
		reg_rd(ADDR_EXT_FLAGS, 8'h00);
		main_ext_mask = 1'b0;
		reg_rd(ADDR_EXT_FLAGS, 8'h02);
		reg_rd(ADDR_EXT_FLAGS, 8'h00);
		`CHK("summary", 1'b0, ext_summary)
		for (int k = 7; k >= 0; k--) begin
			pulse(k);
			`CHK("summary", 1'b1, ext_summary)
			`CHK("self reset", (k == 5 || k == 6), tx_self_reset)
			reg_rd(ADDR_EXT_FLAGS, 8'h01 << k);
		end
		reg_rd(ADDR_RX_STATUS, 8'h20);
		pulse(8);
		reg_rd(ADDR_RX_STATUS, 8'h60);
		reg_rd(ADDR_EXT_FLAGS, 8'h80);
		pulse(9);
		reg_rd(ADDR_RX_STATUS, 8'h70);
		pulse(14);
		reg_rd(ADDR_RX_STATUS, 8'h20);
		pulse(10);
		reg_rd(ADDR_TX_STATUS, 8'h20);
		`CHK("idle fill", 1'b0, tx_idle_fill)
		pulse(12);
		reg_rd(ADDR_TX_STATUS, 8'hA0);
		pulse(11);
		reg_rd(ADDR_TX_STATUS, 8'h80);
		`CHK("idle fill", 1'b1, tx_idle_fill)
		pulse(10);
		pulse(5);
		reg_rd(ADDR_TX_STATUS, 8'h80);
		reg_rd(ADDR_EXT_FLAGS, 8'h20);
		pulse(10);
		reg_rd(ADDR_TX_STATUS, 8'hA0);
		pulse(13);
		reg_rd(ADDR_TX_STATUS, 8'h00);
		rx_frame(8'h55, 8'h66, 1, 1'b0, 8'h00, {VER, 6'h00});
		wait_q(3);
		`CHK("first byte", 8'h55, rx_peer_i.got_q[0])
		`CHK("second byte", 8'h66, rx_peer_i.got_q[1])
		`CHK("third byte", 8'h00, rx_peer_i.got_q[2])
		rx_peer_i.stall = 1'b1;
		rx_frame(8'h08, 8'h09, 30, 1'b1, 8'h20, {VER, 6'h00});
		rx_peer_i.stall = 1'b0;
		wait_q(35);
		`CHK("refused", 1'b1, rx_peer_i.n_refused > 0)
		rx_peer_i.frame(8'h55, 8'h66, 0, 1'b0, ok);
		rx_peer_i.frame(8'h55, 8'h66, 0, 1'b1, ok);
		reg_rd(ADDR_RX_STATUS, 8'h00);
		pulse(15);
		rx_frame(8'h01, 8'h02, 8190, 1'b0, 8'h00, {VER, 6'h20});
		n_exp = 8231;
		wait_q(n_exp);
		reg_wr(ADDR_FA_MASK, 8'h02);
		reg_wr(ADDR_FA_MATCH_A, 8'h10);
		reg_wr(ADDR_SA_MATCH_B, 8'h45);
		for (int k = 0; k < 5; k++) begin
			rx_peer_i.frame(a0s[k], a1s[k], 0, 1'b0, ok);
			pulse(15);
			n_exp += keep[k];
			wait_q(n_exp);
		end
		reg_wr(ADDR_SA_MASK, 8'h02);
		rx_peer_i.frame(8'h10, 8'h47, 0, 1'b0, ok);
		wait_q(n_exp + 2);
		complete_run();
	end
endmodule // tb_top

// [hdl/dchan_hdlc_status_addr_filter.sv]
`timescale 1ns/1ps

module byte_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         CLK,
	input  wire logic         RESET_N,
	input  wire logic         CE,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0]  mem_ff [D];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_ff != (AW+1)'(D));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ff];
	assign push      = in_valid & in_ready & CE;
	assign pop       = out_valid & out_ready & CE;

	always_ff @(posedge CLK) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(D-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(D-1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // byte_fifo

// What this block does
// - Receive data or frame overflow sets the receive overflow event.
// - Transmit underrun raises event, self-resets transmitter, sends all-ones fill.
// - Collision on the bus sets event and self-resets transmitter.
// - Timer expiries set their own events.
// - Serial bus event bit set by any pending serial bus event; stays latched until read.
// - Indication code change and S-channel change each raise an event.
// - Mask bit one hides the event on read; it stays latched.
// - Main extended mask hides every extended event on read.
// - Overwrite status set on overwrite, cleared only by transmit reset.
// - Busy reads one from opening flag until closing flag sent, underrun, collision or transmit reset.
// - Data overflow sets status and event; frame overflow only event.
// - Checksum status zero when correct, one on error.
// - Seven ones mark frame aborted; host then resets receiver.
// - Receive checksum status latched at frame end, held until acknowledge.
// - First mask bits exclude compare; group addresses always stored.
// - Store frame when both address bytes match either register.
// - All first mask bits zero accepts every address.
// - Second mask bits exclude compare against both second registers.
// - Length overflow set at 8192 bytes; held frame end to acknowledge.
// - Byte count split five high, eight low bits.
// - At frame end available bytes equal low five bits, or 32.
// - Summary output clears only when all extended events cleared.
module dchan_hdlc_status_addr_filter
	import dchan_pkg::*;
#(
	parameter logic [1:0] VERSION      = 2'b10, // Arbitrary value
	parameter logic [7:0] GROUP_FIRST  = dchan_pkg::GROUP_FIRST_RST,
	parameter logic [7:0] GROUP_SECOND = dchan_pkg::GROUP_SECOND_RST,
	parameter int         FIFO_DEPTH   = 4
) (
	input  wire logic       CLK,
	input  wire logic       RESET_N,
	input  wire logic       CE,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic [7:0]      RDATA,
	input  wire logic       MAIN_EXT_MASK,
	output logic            EXT_SUMMARY,
	input  wire logic       TRANSMIT_RESET_CMD,
	input  wire logic       RECEIVE_RESET_CMD,
	input  wire logic       RECEIVE_ACK_CMD,
	input  wire logic       TX_UNDERRUN,
	input  wire logic       TX_COLLISION,
	input  wire logic       TX_OVERWRITE,
	input  wire logic       TX_OPEN_FLAG,
	input  wire logic       TX_CLOSE_DONE,
	output logic            TX_SELF_RESET,
	output logic            TX_IDLE_FILL,
	input  wire logic       TIMER1_EXPIRED,
	input  wire logic       TIMER2_ZERO,
	input  wire logic       SERIAL_BUS_PENDING,
	input  wire logic [3:0] INDICATION_CODE,
	input  wire logic [3:0] S_CHANNEL_BITS,
	input  wire logic       RX_DATA_OVERFLOW,
	input  wire logic       RX_FRAME_OVERFLOW,
	input  wire logic       RX_ABORT,
	input  wire logic       RX_SOF,
	input  wire logic       RX_VALID,
	input  wire logic [7:0] RX_DATA,
	output logic            RX_IN_READY,
	input  wire logic       RX_EOF,
	input  wire logic       RX_CRC_ERR,
	output logic            RX_OUT_VALID,
	input  wire logic       RX_OUT_READY,
	output logic [7:0]      RX_OUT_DATA,
	output logic [5:0]      RX_AVAIL
);
	import dchan_pkg::*;

	ext_ev_t           flags_ff;
	logic [7:0]        mask_ff;
	logic [7:0]        fa_mask_ff;
	logic [7:0]        fa_a_ff;
	logic [7:0]        fa_b_ff;
	logic [7:0]        sa_mask_ff;
	logic [7:0]        sa_a_ff;
	logic [7:0]        sa_b_ff;
	tx_status_t        tx_st_ff;
	rx_status_t        rx_st_ff;
	logic              ovf_ff;
	logic              abort_ff;
	logic [CNT_W-1:0]  cnt_ff;
	logic              lov_ff;
	logic [CNT_W-1:0]  rep_cnt_ff;
	logic              rep_lov_ff;
	logic              pending_ff;
	logic [3:0]        ind_ff;
	logic [3:0]        sch_ff;
	logic [7:0]        hold0_ff;
	logic [7:0]        hold1_ff;
	filt_st_t          st_ff;
	filt_st_t          nxt_st;
	logic              self_rst_ff;
	logic [7:0]        rdata_ff;
	logic [5:0]        avail_ff;
	ext_ev_t           set_ev;
	logic [7:0]        visible;
	logic              rd_flags;
	logic              wr_en;
	logic              in_fire;
	logic              first_hit;
	logic              second_hit;
	logic              group_hit;
	logic              accept;
	logic              push_v;
	logic [7:0]        push_d;
	logic              fifo_ready;
	logic              latch_rep;

	assign wr_en    = WR & CE;
	assign rd_flags = RD & CE & (ADDR == ADDR_EXT_FLAGS);

	always_comb begin
		set_ev                         = '0;
		set_ev.receive_overflow_flag   = RX_DATA_OVERFLOW | RX_FRAME_OVERFLOW;
		set_ev.transmit_underrun_flag  = TX_UNDERRUN;
		set_ev.transmit_collision_flag = TX_COLLISION;
		set_ev.second_timer_expired    = TIMER2_ZERO;
		set_ev.serial_bus_event        = SERIAL_BUS_PENDING;
		set_ev.indication_code_changed = (INDICATION_CODE != ind_ff);
		set_ev.first_timer_expired     = TIMER1_EXPIRED;
		set_ev.s_channel_changed       = (S_CHANNEL_BITS != sch_ff);
	end

	assign visible = flags_ff & ~mask_ff & {8{~MAIN_EXT_MASK}};

	// read clears shown events, set wins
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			flags_ff <= EXT_FLAGS_RST;
		end else if (CE) begin
			flags_ff <= (flags_ff & ~(rd_flags ? visible : BYTE_ZERO)) | set_ev;
		end
	end

	assign EXT_SUMMARY = |flags_ff;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ind_ff <= '0;
			sch_ff <= '0;
		end else if (CE) begin
			ind_ff <= INDICATION_CODE;
			sch_ff <= S_CHANNEL_BITS;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mask_ff    <= EXT_MASK_RST;
			fa_mask_ff <= MATCH_RST;
			fa_a_ff    <= MATCH_RST;
			fa_b_ff    <= MATCH_RST;
			sa_mask_ff <= MATCH_RST;
			sa_a_ff    <= MATCH_RST;
			sa_b_ff    <= MATCH_RST;
		end else if (wr_en) begin
			case (ADDR)
				ADDR_EXT_MASK:   mask_ff    <= WDATA;
				ADDR_FA_MASK:    fa_mask_ff <= WDATA;
				ADDR_FA_MATCH_A: fa_a_ff    <= WDATA;
				ADDR_FA_MATCH_B: fa_b_ff    <= WDATA;
				ADDR_SA_MASK:    sa_mask_ff <= WDATA;
				ADDR_SA_MATCH_A: sa_a_ff    <= WDATA;
				ADDR_SA_MATCH_B: sa_b_ff    <= WDATA;
				default: ;
			endcase
		end
	end

	// transmitter self reset and idle fill
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			self_rst_ff <= 1'b0;
		end else if (CE) begin
			self_rst_ff <= TX_UNDERRUN | TX_COLLISION;
		end
	end
	assign TX_SELF_RESET = self_rst_ff;
	assign TX_IDLE_FILL  = ~tx_st_ff.transmitter_busy_flag;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tx_st_ff <= '0;
		end else if (CE) begin
			if (TX_OVERWRITE) begin
				tx_st_ff.tx_fifo_overwritten <= 1'b1;
			end else if (TRANSMIT_RESET_CMD) begin
				tx_st_ff.tx_fifo_overwritten <= 1'b0;
			end
			if (TX_OPEN_FLAG) begin
				tx_st_ff.transmitter_busy_flag <= 1'b1;
			end else if (TX_CLOSE_DONE | TX_UNDERRUN | TX_COLLISION | TRANSMIT_RESET_CMD) begin
				tx_st_ff.transmitter_busy_flag <= 1'b0;
			end
		end
	end

	// live overflow and abort, cleared by receiver reset
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ovf_ff   <= 1'b0;
			abort_ff <= 1'b0;
		end else if (CE) begin
			if (RX_DATA_OVERFLOW) begin
				ovf_ff <= 1'b1;
			end else if (RECEIVE_RESET_CMD) begin
				ovf_ff <= 1'b0;
			end
			if (RX_ABORT) begin
				abort_ff <= 1'b1;
			end else if (RECEIVE_RESET_CMD) begin
				abort_ff <= 1'b0;
			end
		end
	end

	assign first_hit  = ((hold0_ff ^ fa_a_ff) & ~fa_mask_ff) == BYTE_ZERO
		| ((hold0_ff ^ fa_b_ff) & ~fa_mask_ff) == BYTE_ZERO;
	assign second_hit = ((RX_DATA ^ sa_a_ff) & ~sa_mask_ff) == BYTE_ZERO
		| ((RX_DATA ^ sa_b_ff) & ~sa_mask_ff) == BYTE_ZERO;
	assign group_hit  = ((hold0_ff & GROUP_FIRST_CMP) == (GROUP_FIRST & GROUP_FIRST_CMP))
		| (RX_DATA == GROUP_SECOND);
	assign accept     = (fa_mask_ff == BYTE_ZERO) | group_hit | (first_hit & second_hit);

	assign RX_IN_READY = fifo_ready & (st_ff != ST_FLUSH);
	assign in_fire     = RX_VALID & RX_IN_READY & CE;

	always_comb begin
		nxt_st = st_ff;
		push_v = 1'b0;
		push_d = RX_DATA;
		case (st_ff)
			ST_ADDR1: begin
				if (in_fire) begin
					nxt_st = ST_ADDR2;
				end
			end
			ST_ADDR2: begin
				if (in_fire) begin
					nxt_st = accept ? ST_FLUSH : ST_DROP;
					push_v = accept;
					push_d = hold0_ff;
				end
			end
			ST_FLUSH: begin
				push_v = 1'b1;
				push_d = hold1_ff;
				if (fifo_ready) begin
					nxt_st = ST_PASS;
				end
			end
			ST_PASS: begin
				push_v = RX_VALID & RX_IN_READY;
			end
			ST_DROP: ;
			default: nxt_st = ST_ADDR1;
		endcase
		if (RX_SOF | RX_EOF | RECEIVE_RESET_CMD) begin
			nxt_st = ST_ADDR1;
		end
		if (RX_SOF & in_fire) begin
			nxt_st = ST_ADDR2;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_ff    <= ST_ADDR1;
			hold0_ff <= BYTE_ZERO;
			hold1_ff <= BYTE_ZERO;
		end else if (CE) begin
			st_ff <= nxt_st;
			if (in_fire & (RX_SOF | st_ff == ST_ADDR1)) begin
				hold0_ff <= RX_DATA;
			end
			if (in_fire & st_ff == ST_ADDR2) begin
				hold1_ff <= RX_DATA;
			end
		end
	end

	byte_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
		.CLK       (CLK),
		.RESET_N   (RESET_N),
		.CE        (CE),
		.in_valid  (push_v),
		.in_ready  (fifo_ready),
		.in_data   (push_d),
		.out_valid (RX_OUT_VALID),
		.out_ready (RX_OUT_READY),
		.out_data  (RX_OUT_DATA)
	);

	// frame length counter with length overflow
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt_ff <= '0;
			lov_ff <= 1'b0;
		end else if (CE) begin
			if (RX_SOF | RECEIVE_RESET_CMD) begin
				cnt_ff <= CNT_W'(in_fire & RX_SOF);
				lov_ff <= 1'b0;
			end else if (in_fire) begin
				cnt_ff <= cnt_ff + 1'b1;
				if (cnt_ff == '1) begin
					lov_ff <= 1'b1;
				end
			end
		end
	end

	assign latch_rep = RX_EOF & ~pending_ff & CE;

	// report latched at frame end until acknowledge
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pending_ff <= 1'b0;
			rx_st_ff   <= RX_STATUS_RST;
			rep_cnt_ff <= '0;
			rep_lov_ff <= 1'b0;
			avail_ff   <= '0;
		end else if (CE) begin
			if (latch_rep) begin
				pending_ff                   <= 1'b1;
				rx_st_ff.checksum_error_flag <= RX_CRC_ERR;
				rep_cnt_ff                   <= cnt_ff;
				rep_lov_ff                   <= lov_ff;
				avail_ff <= (cnt_ff[AVL_LSB-1:0] == '0) ? AVL_FULL
					: AVL_W'(cnt_ff[AVL_LSB-1:0]);
			end else if (RECEIVE_ACK_CMD | RECEIVE_RESET_CMD) begin
				pending_ff <= 1'b0;
			end
			rx_st_ff.overflow             <= ovf_ff | RX_DATA_OVERFLOW;
			rx_st_ff.receive_aborted_flag <= abort_ff | RX_ABORT;
		end
	end
	assign RX_AVAIL = avail_ff;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_ff <= BYTE_ZERO;
		end else if (RD & CE) begin
			case (ADDR)
				ADDR_EXT_FLAGS: rdata_ff <= visible;
				ADDR_EXT_MASK:  rdata_ff <= mask_ff;
				ADDR_TX_STATUS: rdata_ff <= tx_st_ff;
				ADDR_RX_STATUS: rdata_ff <= rx_st_ff;
				ADDR_FA_MASK:   rdata_ff <= fa_mask_ff;
				ADDR_FA_MATCH_A: rdata_ff <= fa_a_ff;
				ADDR_FA_MATCH_B: rdata_ff <= fa_b_ff;
				ADDR_SA_MASK:   rdata_ff <= sa_mask_ff;
				ADDR_SA_MATCH_A: rdata_ff <= sa_a_ff;
				ADDR_SA_MATCH_B: rdata_ff <= sa_b_ff;
				ADDR_CNT_HIGH:  rdata_ff <= {VERSION, rep_lov_ff, rep_cnt_ff[CNT_W-1:CNT_LOW]};
				ADDR_CNT_LOW:   rdata_ff <= rep_cnt_ff[CNT_LOW-1:0];
				default:        rdata_ff <= BYTE_ZERO;
			endcase
		end
	end
	assign RDATA = rdata_ff;

	property p_underrun;
		@(posedge CLK) disable iff (!RESET_N)
		CE && TX_UNDERRUN |=> flags_ff.transmit_underrun_flag && TX_SELF_RESET && TX_IDLE_FILL;
	endproperty
	a_underrun: assert property (p_underrun) else $error("underrun not handled");
	property p_collision;
		@(posedge CLK) disable iff (!RESET_N)
		CE && TX_COLLISION |=> flags_ff.transmit_collision_flag && TX_SELF_RESET;
	endproperty
	a_collision: assert property (p_collision) else $error("collision not handled");
	property p_mask;
		@(posedge CLK) disable iff (!RESET_N)
		rd_flags |=> (RDATA & $past(mask_ff)) == BYTE_ZERO;
	endproperty
	a_mask: assert property (p_mask) else $error("masked event visible");
	property p_main_mask;
		@(posedge CLK) disable iff (!RESET_N)
		rd_flags && MAIN_EXT_MASK |=> RDATA == BYTE_ZERO
			&& (flags_ff & $past(flags_ff)) == $past(flags_ff);
	endproperty
	a_main_mask: assert property (p_main_mask) else $error("main mask ignored");
	property p_overwrite;
		@(posedge CLK) disable iff (!RESET_N)
		tx_st_ff.tx_fifo_overwritten && !(CE && TRANSMIT_RESET_CMD)
		|=> tx_st_ff.tx_fifo_overwritten;
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("overwrite lost");
	property p_busy;
		@(posedge CLK) disable iff (!RESET_N)
		CE && TX_OPEN_FLAG |=> tx_st_ff.transmitter_busy_flag;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not set");
	property p_crc;
		@(posedge CLK) disable iff (!RESET_N)
		latch_rep |=> rx_st_ff.checksum_error_flag == $past(RX_CRC_ERR) && pending_ff;
	endproperty
	a_crc: assert property (p_crc) else $error("checksum status wrong");
	property p_hold;
		@(posedge CLK) disable iff (!RESET_N)
		pending_ff && !RECEIVE_ACK_CMD && !RECEIVE_RESET_CMD |=> $stable(rep_cnt_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("report changed before ack");
	property p_any_addr;
		@(posedge CLK) disable iff (!RESET_N)
		in_fire && st_ff == ST_ADDR2 && !RX_SOF && !RX_EOF && !RECEIVE_RESET_CMD
			&& fa_mask_ff == BYTE_ZERO |-> push_v ##1 st_ff == ST_FLUSH;
	endproperty
	a_any_addr: assert property (p_any_addr) else $error("open filter dropped frame");
	property p_summary;
		@(posedge CLK) disable iff (!RESET_N)
		CE && TIMER1_EXPIRED |=> EXT_SUMMARY;
	endproperty
	a_summary: assert property (p_summary) else $error("summary missing");
endmodule // dchan_hdlc_status_addr_filter

// [hdl/dchan_pkg.sv]
package dchan_pkg;
	localparam logic [7:0] ADDR_EXT_FLAGS  = 8'h06;
	localparam logic [7:0] ADDR_EXT_MASK   = 8'h07;
	localparam logic [7:0] ADDR_TX_STATUS  = 8'h0A;
	localparam logic [7:0] ADDR_RX_STATUS  = 8'h0B;
	localparam logic [7:0] ADDR_FA_MASK    = 8'h0E;
	localparam logic [7:0] ADDR_FA_MATCH_A = 8'h0F;
	localparam logic [7:0] ADDR_FA_MATCH_B = 8'h10;
	localparam logic [7:0] ADDR_SA_MASK    = 8'h11;
	localparam logic [7:0] ADDR_SA_MATCH_A = 8'h12;
	localparam logic [7:0] ADDR_SA_MATCH_B = 8'h13;
	localparam logic [7:0] ADDR_CNT_HIGH   = 8'h16;
	localparam logic [7:0] ADDR_CNT_LOW    = 8'h17;

	localparam logic [7:0] EXT_FLAGS_RST = 8'h00;
	localparam logic [7:0] EXT_MASK_RST  = 8'hFF;
	localparam logic [7:0] MATCH_RST     = 8'h00;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;

	// Group addresses; first byte compares only the upper six bits
	localparam logic [7:0] GROUP_FIRST_RST  = 8'hFC;
	localparam logic [7:0] GROUP_FIRST_CMP  = 8'hFC;
	localparam logic [7:0] GROUP_SECOND_RST = 8'hFF;

	localparam int CNT_W   = 13;
	localparam int CNT_LOW = 8;
	localparam int AVL_W   = 6;
	localparam int AVL_LSB = 5;
	localparam logic [AVL_W-1:0] AVL_FULL = 6'h20;

	typedef struct packed {
		logic receive_overflow_flag;
		logic transmit_underrun_flag;
		logic transmit_collision_flag;
		logic second_timer_expired;
		logic serial_bus_event;
		logic indication_code_changed;
		logic first_timer_expired;
		logic s_channel_changed;
	} ext_ev_t;

	typedef struct packed {
		logic       pad7;
		logic       overflow;
		logic       checksum_error_flag;
		logic       receive_aborted_flag;
		logic [3:0] pad;
	} rx_status_t;

	localparam rx_status_t RX_STATUS_RST = 8'h20;

	typedef struct packed {
		logic       tx_fifo_overwritten;
		logic       pad6;
		logic       transmitter_busy_flag;
		logic [4:0] pad;
	} tx_status_t;

	typedef enum logic [4:0] {
		ST_ADDR1 = 5'b00001,
		ST_ADDR2 = 5'b00010,
		ST_FLUSH = 5'b00100,
		ST_PASS  = 5'b01000,
		ST_DROP  = 5'b10000
	} filt_st_t;
endpackage
